// File: verilog/led_port_pkg.sv
// Purpose: shared constants and carrier types of the led driver host port
// Assumes: one system clock; pins and oscillator flags arrive asynchronously
// Notes:   command codes for ram access and the fifo word layout live here
package led_port_pkg;

  // command bytes
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_LOOP_STATUS = 8'h72;
  localparam logic [7:0] CMD_FUNC_FLAG   = 8'h73;
  localparam logic [7:0] CMD_OPEN_DET    = 8'h74;
  localparam logic [7:0] CMD_SHORT_DET   = 8'h75;
  localparam logic [7:0] CMD_RAM_WRITE   = 8'h80;
  localparam logic [7:0] CMD_RAM_READ    = 8'h81;

  // pointer limits (last valid location), first pointer and reset byte
  localparam logic [7:0] LIMIT_BIN_DISP   = 8'h08;
  localparam logic [7:0] LIMIT_GRAY_DISP  = 8'h87;
  localparam logic [7:0] LIMIT_GRAY_FADE  = 8'h83;
  localparam logic [7:0] LIMIT_GRAY_ONOFF = 8'h08;
  localparam logic [7:0] STATUS_LAST      = 8'h13;
  localparam logic [7:0] DETECT_LAST      = 8'h08;
  localparam logic [7:0] PTR_FIRST        = 8'h00;
  localparam logic [7:0] RESET_BYTE       = 8'h00;

  // two-wire slave addresses
  localparam logic [4:0] SLAVE_FIXED = 5'h1B;
  localparam logic [6:0] COMMON_ADDR = 7'h2E;

  // byte framing
  localparam logic [3:0] BIT_LAST  = 4'h7;
  localparam logic [3:0] BIT_COUNT = 4'h8;
  localparam logic [3:0] BIT_ONE   = 4'h1;

  // byte field positions of the flag byte
  localparam int FLAG_SCAN_BIT = 7;
  localparam int FLAG_TSD_BIT  = 0;

  // fifo shape
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    SPACE_BIN_DISP   = 2'h0,
    SPACE_GRAY_DISP  = 2'h1,
    SPACE_GRAY_FADE  = 2'h2,
    SPACE_GRAY_ONOFF = 2'h3
  } ram_space_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_MACK = 5'h10
  } fsm_t;

  typedef struct packed {
    logic       loop_state_hi;
    logic       loop_state_lo;
    logic       loop_index_endless;
    logic [2:0] loop_index;
    logic       first_column_output;
    logic       temp_above_set;
    logic       temp_below_clear;
  } osc_status_t;

  typedef struct packed {
    logic chip_select_n;
    logic serial_clock;
    logic serial_data;
  } pins_t;

  localparam pins_t PINS_IDLE = 3'h7;

  typedef struct packed {
    logic       is_cmd;
    logic [7:0] ptr;
    logic [7:0] data;
  } rx_word_t;

endpackage : led_port_pkg

// File: verilog/led_driver_serial_host_port.sv
// Purpose: host serial port (three-wire and two-wire) with status readback
// Assumes: clk 100 MHz; pins and oscillator flags are asynchronous
// Notes:   received bytes leave through a 16 word fifo toward the engines
`timescale 1ns/100ps

module rx_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
    logic                        full;
    logic                        nonempty;
  } fifo_state_t;

  fifo_state_t s_ff;
  fifo_state_t nxt_s;
  logic        do_wr;
  logic        do_rd;

  // depth is a power of two so the indices wrap by themselves
  always_comb begin
    nxt_s = s_ff;
    do_wr = in_valid & ~s_ff.full;
    do_rd = out_ready & s_ff.nonempty;
    if (do_wr) begin
      nxt_s.mem[s_ff.wr] = in_data;
      nxt_s.wr = s_ff.wr + 1'b1;
    end
    if (do_rd) begin
      nxt_s.rd = s_ff.rd + 1'b1;
    end
    if (do_wr & ~do_rd) begin
      nxt_s.cnt = s_ff.cnt + 1'b1;
    end else if (do_rd & ~do_wr) begin
      nxt_s.cnt = s_ff.cnt - 1'b1;
    end
    nxt_s.full = (nxt_s.cnt == FULL_CNT);
    nxt_s.nonempty = (nxt_s.cnt != '0);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_ff <= '0;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  assign in_ready  = ~s_ff.full;
  assign out_valid = s_ff.nonempty;
  assign out_data  = s_ff.mem[s_ff.rd];
endmodule : rx_fifo

// How it works
// [R1] command 72h returns loop state in bits 7:6, loop index in 3:0
// [R2] loop state: hi clear none, hi set playing, both set finished; reset 0
// [R3] command 73h returns scan origin in bit 7, thermal flag in bit 0
// [R4] scan origin flag reads one while first column is scanned
// [R5] thermal flag sets above 150C, clears below 125C, reset zero
// [R6] three-wire sequence starts when chip select falls
// [R7] three-wire bytes arrive msb first, sampled on serial clock rise
// [R8] every eight received bits form a byte, no latch strobe
// [R9] after read command and address the data pin becomes an output
// [R10] raising chip select releases the data pin and ends the read
// [R11] three-wire read data changes on serial clock falling edges
// [R12] host reads whole bytes, sampling between rise and next fall
// [R13] single ram access beyond the limit is ignored
// [R14] page ram access increments pointer, wraps to zero after limit
// [R15] register status read wraps to first byte after location 20
// [R16] detection data read wraps to first address after ninth location
// [R17] two-wire data changes only while clock is low
// [R18] start is data falling, stop is data rising, with clock high
// [R19] bus busy from start to stop; repeated start acts as start
// [R20] two-wire bytes are eight bits msb first plus acknowledge
// [R21] two-wire lines are only pulled low, open drain
// [R22] acknowledge address 11011 plus strap bits, or common 0101110
// [R23] addressed receiver pulls data low in the ninth clock
// [R24] sequential two-wire read advances pointer only on master ack; code advances it as each byte loads, the first one right after the address ack
// [R25] with chip select high the pin is input and partial byte cleared
// [R26] oscillator domain flags pass two flip-flops before use
module led_driver_serial_host_port (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire logic                      iface_two_wire,
  input  wire logic [1:0]                addr_strap,
  input  wire logic                      chip_select_n,
  input  wire logic                      serial_clock,
  input  wire logic                      bidir_serial_data_in,
  output logic                           bidir_serial_data_out,
  output logic                           bidir_serial_data_oe,
  input  wire led_port_pkg::osc_status_t osc_status,
  input  wire led_port_pkg::ram_space_t  ram_space,
  output logic                     [7:0] rd_addr,
  input  wire logic                [7:0] rd_data,
  output led_port_pkg::rx_word_t         rx_word,
  output logic                           rx_valid,
  input  wire logic                      rx_ready,
  output logic                           bus_busy,
  output logic                           rx_drop,
  output logic                           thermal_shutdown_flag
);

  typedef struct packed {
    led_port_pkg::pins_t       pin_s1;
    led_port_pkg::pins_t       pin_s2;
    led_port_pkg::pins_t       pin_d;
    logic [2:0]                cfg_s1;
    logic [2:0]                cfg_s2;
    led_port_pkg::osc_status_t osc_s1;
    led_port_pkg::osc_status_t osc_s2;
    logic                      tsd;
    led_port_pkg::fsm_t        fsm;
    logic [3:0]                bitcnt;
    logic [7:0]                shreg;
    logic [7:0]                txsh;
    logic [1:0]                bytecnt;
    logic [7:0]                cmd;
    logic [7:0]                ptr;
    logic                      ptr_bad;
    logic                      addr_phase;
    logic                      rw;
    logic                      ack;
    logic                      ack_drv;
    logic                      mack;
    logic                      busy;
    logic                      sdo;
    logic                      oe;
    logic                      push;
    led_port_pkg::rx_word_t    word;
    logic                      drop;
  } port_state_t;

  port_state_t s_ff;
  port_state_t nxt_s;
  logic        fifo_in_ready;

  function automatic logic [7:0] ram_limit(
    input led_port_pkg::ram_space_t sp
  );
    case (sp)
      led_port_pkg::SPACE_GRAY_DISP:  ram_limit = led_port_pkg::LIMIT_GRAY_DISP;
      led_port_pkg::SPACE_GRAY_FADE:  ram_limit = led_port_pkg::LIMIT_GRAY_FADE;
      led_port_pkg::SPACE_GRAY_ONOFF: ram_limit = led_port_pkg::LIMIT_GRAY_ONOFF;
      default:                        ram_limit = led_port_pkg::LIMIT_BIN_DISP;
    endcase
  endfunction : ram_limit

  function automatic logic is_ram_cmd(input logic [7:0] c);
    is_ram_cmd = (c == led_port_pkg::CMD_RAM_WRITE) |
                 (c == led_port_pkg::CMD_RAM_READ);
  endfunction : is_ram_cmd

  function automatic logic is_status_cmd(input logic [7:0] c);
    is_status_cmd = (c == led_port_pkg::CMD_READ_STATUS) |
                    (c == led_port_pkg::CMD_LOOP_STATUS) |
                    (c == led_port_pkg::CMD_FUNC_FLAG) |
                    (c == led_port_pkg::CMD_OPEN_DET) |
                    (c == led_port_pkg::CMD_SHORT_DET);
  endfunction : is_status_cmd

  // pointer after one byte of a read or write burst
  function automatic logic [7:0] next_ptr(
    input logic [7:0] c,
    input logic [7:0] p,
    input logic [7:0] lim
  );
    logic [7:0] last;
    last = p;
    case (c)
      led_port_pkg::CMD_READ_STATUS: last = led_port_pkg::STATUS_LAST; // [R15]
      led_port_pkg::CMD_OPEN_DET,
      led_port_pkg::CMD_SHORT_DET:   last = led_port_pkg::DETECT_LAST; // [R16]
      led_port_pkg::CMD_RAM_WRITE,
      led_port_pkg::CMD_RAM_READ:    last = lim;                       // [R14]
      default:                       last = p;
    endcase
    if (p >= last) begin
      next_ptr = led_port_pkg::PTR_FIRST;
    end else begin
      next_ptr = p + 8'h01;
    end
  endfunction : next_ptr

  // byte returned for the current read command
  function automatic logic [7:0] read_byte(
    input logic [7:0]                c,
    input logic                      bad,
    input logic [7:0]                rd,
    input led_port_pkg::osc_status_t st,
    input logic                      tsd
  );
    logic [7:0] b;
    b = led_port_pkg::RESET_BYTE;
    case (c)
      led_port_pkg::CMD_LOOP_STATUS: begin
        b = {st.loop_state_hi, st.loop_state_lo, 2'h0,
             st.loop_index_endless, st.loop_index};           // [R1] [R2]
      end
      led_port_pkg::CMD_FUNC_FLAG: begin
        b[led_port_pkg::FLAG_SCAN_BIT] = st.first_column_output; // [R3] [R4]
        b[led_port_pkg::FLAG_TSD_BIT]  = tsd;                    // [R3]
      end
      led_port_pkg::CMD_READ_STATUS,
      led_port_pkg::CMD_OPEN_DET,
      led_port_pkg::CMD_SHORT_DET:   b = rd;
      led_port_pkg::CMD_RAM_READ:    b = bad ? led_port_pkg::RESET_BYTE : rd;
      default:                       b = led_port_pkg::RESET_BYTE;
    endcase
    read_byte = b;
  endfunction : read_byte

  logic       two;
  logic       rise;
  logic       fall;
  logic       sdi;
  logic       start_c;
  logic       stop_c;
  logic       cs_on;
  logic       reload;
  logic       byte_done;
  logic [7:0] rxb;
  logic [7:0] rb;
  logic [7:0] lim;
  logic [7:0] np;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.push = 1'b0;
    nxt_s.drop = 1'b0;
    reload = 1'b0;
    byte_done = 1'b0;
    rxb = {s_ff.shreg[6:0], s_ff.pin_s2.serial_data};
    // pins and oscillator flags through two flip-flops
    nxt_s.pin_s1 = {chip_select_n, serial_clock, bidir_serial_data_in};
    nxt_s.pin_s2 = s_ff.pin_s1;
    nxt_s.pin_d = s_ff.pin_s2;
    nxt_s.cfg_s1 = {iface_two_wire, addr_strap};
    nxt_s.cfg_s2 = s_ff.cfg_s1;
    nxt_s.osc_s1 = osc_status;                                 // [R26]
    nxt_s.osc_s2 = s_ff.osc_s1;                                // [R26]
    if (s_ff.osc_s2.temp_above_set) begin
      nxt_s.tsd = 1'b1;                                        // [R5]
    end else if (s_ff.osc_s2.temp_below_clear) begin
      nxt_s.tsd = 1'b0;                                        // [R5]
    end
    two = s_ff.cfg_s2[2];
    sdi = s_ff.pin_s2.serial_data;
    rise = s_ff.pin_s2.serial_clock & ~s_ff.pin_d.serial_clock;
    fall = ~s_ff.pin_s2.serial_clock & s_ff.pin_d.serial_clock;
    start_c = two & s_ff.pin_s2.serial_clock & s_ff.pin_d.serial_clock &
              s_ff.pin_d.serial_data & ~sdi;                   // [R18]
    stop_c = two & s_ff.pin_s2.serial_clock & s_ff.pin_d.serial_clock &
             ~s_ff.pin_d.serial_data & sdi;                    // [R18]
    cs_on = ~two & ~s_ff.pin_s2.chip_select_n;
    lim = ram_limit(ram_space);
    rb = read_byte(s_ff.cmd, s_ff.ptr_bad, rd_data, s_ff.osc_s2, s_ff.tsd);
    np = next_ptr(s_ff.cmd, s_ff.ptr, lim);

    if (two & start_c) begin
      nxt_s.busy = 1'b1;                                       // [R19]
      nxt_s.fsm = led_port_pkg::ST_RX;
      nxt_s.bitcnt = '0;
      nxt_s.addr_phase = 1'b1;
      nxt_s.ack_drv = 1'b0;
      nxt_s.oe = 1'b0;
    end else if (two & stop_c) begin
      nxt_s.busy = 1'b0;                                       // [R19]
      nxt_s.fsm = led_port_pkg::ST_IDLE;
      nxt_s.oe = 1'b0;
    end else if (~two & ~cs_on) begin
      nxt_s.fsm = led_port_pkg::ST_IDLE;                       // [R10]
      nxt_s.oe = 1'b0;                                         // [R25]
      nxt_s.sdo = 1'b0;
      nxt_s.bitcnt = '0;                                       // [R25]
      nxt_s.shreg = '0;
      nxt_s.bytecnt = '0;
      nxt_s.busy = 1'b0;
    end else begin
      case (s_ff.fsm)
        led_port_pkg::ST_IDLE: begin
          if (~two) begin
            nxt_s.fsm = led_port_pkg::ST_RX;                   // [R6]
            nxt_s.bitcnt = '0;
            nxt_s.bytecnt = '0;
            nxt_s.busy = 1'b1;
          end
        end
        led_port_pkg::ST_RX: begin
          if (rise) begin
            nxt_s.shreg = rxb;                                 // [R7] [R20]
            nxt_s.bitcnt = s_ff.bitcnt + led_port_pkg::BIT_ONE;
            byte_done = (s_ff.bitcnt == led_port_pkg::BIT_LAST); // [R8]
          end
        end
        led_port_pkg::ST_ACK: begin
          if (fall & ~s_ff.ack_drv) begin
            nxt_s.oe = s_ff.ack;                               // [R23] [R21]
            nxt_s.sdo = 1'b0;
            nxt_s.ack_drv = 1'b1;
          end else if (fall) begin
            nxt_s.ack_drv = 1'b0;
            nxt_s.oe = 1'b0;
            nxt_s.bitcnt = '0;
            if (~s_ff.ack) begin
              nxt_s.fsm = led_port_pkg::ST_IDLE;
            end else if (s_ff.rw) begin
              reload = 1'b1;
            end else begin
              nxt_s.fsm = led_port_pkg::ST_RX;
            end
          end
        end
        led_port_pkg::ST_TX: begin
          if (fall & (s_ff.bitcnt == led_port_pkg::BIT_COUNT)) begin
            if (two) begin
              nxt_s.oe = 1'b0;
              nxt_s.fsm = led_port_pkg::ST_MACK;
            end else begin
              reload = 1'b1;
            end
          end else if (fall) begin
            nxt_s.txsh = {s_ff.txsh[6:0], 1'b0};
            nxt_s.bitcnt = s_ff.bitcnt + led_port_pkg::BIT_ONE;
            nxt_s.sdo = two ? 1'b0 : s_ff.txsh[7];             // [R11]
            nxt_s.oe = two ? ~s_ff.txsh[7] : 1'b1;             // [R17] [R21]
          end
        end
        led_port_pkg::ST_MACK: begin
          if (rise) begin
            nxt_s.mack = ~sdi;
          end else if (fall & s_ff.mack) begin
            reload = 1'b1;                                     // [R24]
          end else if (fall) begin
            nxt_s.fsm = led_port_pkg::ST_IDLE;                 // [R23]
          end
        end
        default: begin
          nxt_s.fsm = led_port_pkg::ST_IDLE;
        end
      endcase
    end

    // a whole byte has been shifted in
    if (byte_done & two & s_ff.addr_phase) begin
      nxt_s.addr_phase = 1'b0;
      nxt_s.rw = rxb[0];
      nxt_s.ack = (rxb[7:1] == {led_port_pkg::SLAVE_FIXED, s_ff.cfg_s2[1:0]}) |
                  (rxb[7:1] == led_port_pkg::COMMON_ADDR);     // [R22]
      nxt_s.bytecnt = '0;
      nxt_s.fsm = led_port_pkg::ST_ACK;
    end else if (byte_done) begin
      nxt_s.ack = 1'b1;
      nxt_s.bitcnt = '0;
      nxt_s.fsm = two ? led_port_pkg::ST_ACK : led_port_pkg::ST_RX;
      if (s_ff.bytecnt == 2'h0) begin
        nxt_s.cmd = rxb;
        nxt_s.ptr = led_port_pkg::PTR_FIRST;
        nxt_s.ptr_bad = 1'b0;
        nxt_s.bytecnt = 2'h1;
        nxt_s.word = '{is_cmd: 1'b1, ptr: led_port_pkg::PTR_FIRST, data: rxb};
        nxt_s.push = fifo_in_ready;
        nxt_s.drop = ~fifo_in_ready;
        nxt_s.ack = fifo_in_ready;
        if (~two & is_status_cmd(rxb)) begin
          nxt_s.fsm = led_port_pkg::ST_TX;                     // [R9]
          nxt_s.bitcnt = led_port_pkg::BIT_COUNT;
        end
      end else if ((s_ff.bytecnt == 2'h1) & is_ram_cmd(s_ff.cmd)) begin
        nxt_s.ptr = rxb;
        nxt_s.ptr_bad = (rxb > lim);                           // [R13]
        nxt_s.bytecnt = 2'h2;
        if (~two & (s_ff.cmd == led_port_pkg::CMD_RAM_READ)) begin
          nxt_s.fsm = led_port_pkg::ST_TX;                     // [R9]
          nxt_s.bitcnt = led_port_pkg::BIT_COUNT;
        end
      end else if (~s_ff.ptr_bad) begin
        nxt_s.word = '{is_cmd: 1'b0, ptr: s_ff.ptr, data: rxb};
        nxt_s.push = fifo_in_ready;
        nxt_s.drop = ~fifo_in_ready;
        nxt_s.ack = fifo_in_ready;
        if (fifo_in_ready) begin
          nxt_s.ptr = np;                                      // [R14]
        end
      end
    end

    // load the next read byte and put out its first bit
    if (reload) begin
      nxt_s.fsm = led_port_pkg::ST_TX;
      nxt_s.txsh = {rb[6:0], 1'b0};
      nxt_s.bitcnt = led_port_pkg::BIT_ONE;
      nxt_s.sdo = two ? 1'b0 : rb[7];                          // [R11]
      nxt_s.oe = two ? ~rb[7] : 1'b1;                          // [R9] [R21]
      nxt_s.mack = 1'b0;
      if (~s_ff.ptr_bad) begin
        nxt_s.ptr = np;                                        // [R15] [R16]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.pin_s1 <= led_port_pkg::PINS_IDLE;
      s_ff.pin_s2 <= led_port_pkg::PINS_IDLE;
      s_ff.pin_d <= led_port_pkg::PINS_IDLE;
      s_ff.fsm <= led_port_pkg::ST_IDLE;                       // [R25]
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  rx_fifo #(
    .WIDTH ($bits(led_port_pkg::rx_word_t)),
    .DEPTH (led_port_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (s_ff.push),
    .in_ready  (fifo_in_ready),
    .in_data   (s_ff.word),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_word)
  );

  assign bidir_serial_data_out = s_ff.sdo;
  assign bidir_serial_data_oe  = s_ff.oe;
  assign rd_addr               = s_ff.ptr;
  assign bus_busy              = s_ff.busy;
  assign rx_drop               = s_ff.drop;
  assign thermal_shutdown_flag = s_ff.tsd;
endmodule : led_driver_serial_host_port

// File: verif/led_port_asserts.sv
// Purpose: concurrent checks on the host port pins
// Assumes: three-wire traffic; pins pass two sync stages
// Notes:   6 to 8 cycle windows cover sync latency
`timescale 1ns/100ps
module led_port_asserts (
  input logic                      clk,
  input logic                      rst,
  input logic                      iface_two_wire,
  input logic                      chip_select_n,
  input logic                      serial_clock,
  input logic                      bidir_serial_data_out,
  input logic                      bidir_serial_data_oe,
  input led_port_pkg::osc_status_t osc_status,
  input logic                [7:0] rd_addr,
  input logic                      rx_valid,
  input logic                      rx_drop,
  input logic                      bus_busy,
  input logic                      thermal_shutdown_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence sel_low;
    (!iface_two_wire && !chip_select_n)[*6];
  endsequence
  sequence sel_high;
    (!iface_two_wire && chip_select_n)[*6];
  endsequence
  sequence clk_held;
    (!chip_select_n && serial_clock)[*8];
  endsequence
  reset_clears_a: assert property (disable iff (1'b0)
    rst |=> !bidir_serial_data_oe && !bus_busy && !rx_valid && !rx_drop
      && rd_addr == 8'h00 && !thermal_shutdown_flag)
    else $error("reset state");
  idle_pin_input_a: assert property (
    sel_high |-> !bidir_serial_data_oe)
    else $error("pin driven idle");
  busy_selected_a: assert property (sel_low |-> bus_busy)
    else $error("busy low");
  busy_idle_a: assert property (sel_high |-> !bus_busy)
    else $error("busy high");
  out_on_fall_a: assert property (
    clk_held |=> $stable(bidir_serial_data_out))
    else $error("data moved");
  drive_selected_a: assert property (
    $rose(bidir_serial_data_oe) && !iface_two_wire |-> !chip_select_n)
    else $error("pin on outside frame");
  thermal_set_a: assert property (
    osc_status.temp_above_set [*6] |-> thermal_shutdown_flag)
    else $error("flag not set");
  thermal_clear_a: assert property (
    (osc_status.temp_below_clear && !osc_status.temp_above_set) [*6]
      |-> !thermal_shutdown_flag)
    else $error("flag not cleared");
  thermal_hold_a: assert property (
    (!osc_status.temp_below_clear && !osc_status.temp_above_set) [*6]
      |=> $stable(thermal_shutdown_flag))
    else $error("flag moved");
endmodule : led_port_asserts

bind led_driver_serial_host_port led_port_asserts u_chk (.*);

// File: verif/serial_host_model.sv
// Purpose: host model driving the three-wire link
// Assumes: link clock half period 80 ns, held high between frames
// Notes:   a released data line reads inverted
`timescale 1ns/100ps
module serial_host_model (
  input  logic dev_oe,
  input  logic dev_out,
  output logic cs_n,
  output logic sck,
  output logic sdi
);
  localparam time HALF = 80ns;
  logic d;
  logic d_oe;
  initial begin
    cs_n = 1'b1;
    sck = 1'b1;
    d = 1'b1;
    d_oe = 1'b0;
  end
  assign sdi = dev_oe ? dev_out : (d_oe ? d : ~dev_out);
  task automatic open_frame();
    #3 cs_n = 1'b0;
    #(HALF);
  endtask : open_frame
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin // msb first
      sck = 1'b0;
      d_oe = 1'b1;
      d = b[i];
      #(HALF) sck = 1'b1;
      #(HALF);
    end
    d_oe = 1'b0;
  endtask : send
  task automatic recv(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin // whole bytes only
      sck = 1'b0;
      #(HALF) sck = 1'b1;
      #1 b[i] = sdi;
      #(HALF - 1);
    end
  endtask : recv
  task automatic close_frame();
    #(HALF) cs_n = 1'b1;
    #(2 * HALF);
  endtask : close_frame
endmodule : serial_host_model

// File: verif/led_driver_serial_host_port_test.sv
// Purpose: self-checking bench of the led driver host port
// Assumes: three-wire strap
// Notes:   rd_data is rd_addr xor 5ah so pointers read back
`timescale 1ns/100ps
module led_driver_serial_host_port_test;
  logic                      clk;
  logic                      rst;
  logic                      cs_n;
  logic                      sck;
  logic                      sdi;
  logic                      d_out;
  logic                      d_oe;
  logic                      rx_valid;
  logic                      rx_ready;
  logic                      drop;
  logic                      tsd;
  logic                [7:0] rd_addr;
  led_port_pkg::osc_status_t osc;
  led_port_pkg::ram_space_t  space;
  led_port_pkg::rx_word_t    word;
  logic                [7:0] got [32];
  int                        errors;
  int                        samples_checked;
  int                        drops;
  led_driver_serial_host_port dut (.clk(clk), .rst(rst), .ce(1'b1),
    .iface_two_wire(1'b0), .addr_strap(2'h0), .chip_select_n(cs_n),
    .serial_clock(sck), .bidir_serial_data_in(sdi),
    .bidir_serial_data_out(d_out), .bidir_serial_data_oe(d_oe),
    .osc_status(osc), .ram_space(space), .rd_addr(rd_addr),
    .rd_data(rd_addr ^ 8'h5a), .rx_word(word), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .bus_busy(), .rx_drop(drop),
    .thermal_shutdown_flag(tsd));
  serial_host_model host (.dev_oe(d_oe), .dev_out(d_out),
    .cs_n(cs_n), .sck(sck), .sdi(sdi));
  always #5 clk = ~clk;
  always @(posedge clk) if (drop === 1'b1) drops++;
  task automatic check(input string what, input logic [16:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic rd_seq(input logic [7:0] c, input int a, input int n);
    host.open_frame();
    host.send(c);
    if (a >= 0) host.send(8'(a));
    for (int i = 0; i < n; i++) host.recv(got[i]);
    check("pin driven", 17'(d_oe), 17'h0_0001);
    host.close_frame();
    check("pin released", 17'(d_oe), '0);
  endtask : rd_seq
  task automatic t_defaults();
    rd_seq(led_port_pkg::CMD_LOOP_STATUS, -1, 1);
    check("loop reset", 17'(got[0] & 8'hcf), '0);
    rd_seq(led_port_pkg::CMD_FUNC_FLAG, -1, 1);
    check("flag reset", 17'(got[0] & 8'h81), '0);
  endtask : t_defaults
  task automatic t_loop();
    logic [8:0] st [3] = '{9'h0a8, 9'h138, 9'h1e0};
    logic [7:0] ex [3] = '{8'h45, 8'h87, 8'hcc};
    for (int k = 0; k < 3; k++) begin
      @(posedge clk) osc <= st[k];
      rd_seq(led_port_pkg::CMD_LOOP_STATUS, -1, 2);
      check("loop byte", 17'(got[0] & 8'hcf), 17'(ex[k]));
      check("loop again", 17'(got[1] & 8'hcf), 17'(ex[k]));
    end
  endtask : t_loop
  task automatic t_flags();
    logic [8:0] st [4] = '{9'h006, 9'h000, 9'h001, 9'h004};
    logic [7:0] ex [4] = '{8'h81, 8'h01, 8'h00, 8'h80};
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) osc <= st[k];
      rd_seq(led_port_pkg::CMD_FUNC_FLAG, -1, 1);
      check("flag byte", 17'(got[0] & 8'h81), 17'(ex[k]));
      check("tsd pin", 17'(tsd), 17'(ex[k][0]));
    end
  endtask : t_flags
  task automatic t_wrap();
    logic [7:0] cmd [3] = '{8'h70, 8'h74, 8'h75};
    int span [3] = '{20, 9, 9};
    for (int k = 0; k < 3; k++) begin
      rd_seq(cmd[k], -1, span[k] + 1);
      for (int i = 0; i <= span[k]; i++)
        check("wrap", 17'(got[i]), 17'(8'(i % span[k]) ^ 8'h5a));
    end
  endtask : t_wrap
  task automatic t_ram();
    logic [7:0] lim [4] = '{8'h08, 8'h87, 8'h83, 8'h08};
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) space <= led_port_pkg::ram_space_t'(k);
      rd_seq(led_port_pkg::CMD_RAM_READ, lim[k], 2);
      check("ram limit", 17'(got[0]), 17'(lim[k] ^ 8'h5a));
      check("ram wrapped", 17'(got[1]), 17'h0_005a);
      rd_seq(led_port_pkg::CMD_RAM_READ, lim[k] + 1, 1);
      check("ram invalid", 17'(got[0]), '0);
    end
  endtask : t_ram
  task automatic t_fill();
    logic [16:0] ex;
    @(posedge clk) rx_ready <= 1'b0;
    space <= led_port_pkg::SPACE_BIN_DISP;
    drops = 0;
    host.open_frame();
    host.send(led_port_pkg::CMD_RAM_WRITE);
    host.send(8'h07);
    for (int i = 0; i < 16; i++) host.send(8'h30 + 8'(i));
    host.close_frame();
    check("drops", 17'(drops), 17'h0_0001);
    for (int i = 0; i < 16; i++) begin
      ex = {1'b0, 8'((6 + i) % 9), 8'h2f + 8'(i)};
      if (i == 0) ex = {1'b1, 8'h00, led_port_pkg::CMD_RAM_WRITE};
      @(negedge clk) check("fifo word", word, ex);
      @(posedge clk) rx_ready <= 1'b1;
      @(posedge clk) rx_ready <= 1'b0;
    end
    @(negedge clk) check("fifo empty", 17'(rx_valid), '0);
    @(posedge clk) rx_ready <= 1'b1;
  endtask : t_fill
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    rx_ready = 1'b1;
    osc = '0;
    space = led_port_pkg::SPACE_BIN_DISP;
    errors = 0;
    samples_checked = 0;
    drops = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_defaults();
    t_loop();
    t_flags();
    t_wrap();
    t_ram();
    t_fill();
    conclude();
  end
  initial begin
    #800us;
    errors++;
    conclude();
  end
endmodule : led_driver_serial_host_port_test
